// ==== design/clock_event_consts.svh ====
// register offsets, field positions and reset values of the event latch block
`ifndef CLOCK_EVENT_CONSTS_SVH
`define CLOCK_EVENT_CONSTS_SVH

// ********************************************
// register byte offsets
// ********************************************
`define OFS_REF_FLAGS 16'h00e2
`define OFS_LOOP_FLAGS 16'h00e3
`define OFS_SYS_FLAGS 16'h00e4
`define OFS_REF_MASK 16'h00e5
`define OFS_LOOP_MASK 16'h00e6
`define OFS_SYS_MASK 16'h00e7

// ********************************************
// field positions, reference monitor register
// ********************************************
`define BIT_REF0_LT 0
`define BIT_REF0_MT 1
`define BIT_REF1_ST 6

// ********************************************
// field positions, loop registers
// ********************************************
`define BIT_UNLOCK 0
`define BIT_HOLDOVER 1
`define BIT_STATE 2
`define LOOP1_BASE 4
`define BIT_RF_UNLOCK 3
`define BIT_ANALOG_BASE 0

// ********************************************
// implemented bits and reset values
// ********************************************
`define IMPL_REF 8'h43
`define IMPL_LOOP 8'h77
`define IMPL_SYS 8'h7f
`define FLAG_RST 8'h00
`define MASK_RST 8'h00
`define DATA_RST 8'h00

`endif

// ==== design/clock_event_latch.sv ====
// latched clock event flags, interrupt masks and interrupt output
//
// Summary of operation
// - ref0 medium-term failure sets sticky flag
// - ref0 long-term failure sets sticky flag
// - writing one clears flag, zero keeps
// - loop one state change latches flag
// - loop one holdover entry or exit latches
// - loop one lock loss latches flag
// - loop zero state change latches flag
// - loop zero holdover entry or exit latches
// - loop zero lock loss latches flag
// - system loop state change latches flag
// - system loop holdover entry or exit latches
// - system loop lock loss latches flag
// - rf loop lock loss latches flag
// - three analog loop lock-loss flags
// - ref1 short-term mask blocks its interrupt
// - ref1 short-term mask blocks disqualification
// - loop one state mask blocks interrupt
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "clock_event_consts.svh"
module clock_event_latch (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic ce,
   // register port
   input wire clock_event_pkg::reg_addr_t addr,
   input wire clock_event_pkg::reg_byte_t wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   // reference monitor status
   input wire logic ref0_mt_fail,
   input wire logic ref0_lt_fail,
   input wire logic ref1_st_fail,
   // reference loop zero
   input wire clock_event_pkg::loop_state_t loop0_state,
   input wire logic loop0_holdover,
   input wire logic loop0_locked,
   // reference loop one
   input wire clock_event_pkg::loop_state_t loop1_state,
   input wire logic loop1_holdover,
   input wire logic loop1_locked,
   // system phase loop
   input wire clock_event_pkg::loop_state_t sys_state,
   input wire logic sys_holdover,
   input wire logic sys_locked,
   // rf and analog loops
   input wire logic rf_locked,
   input wire logic [2:0] analog_locked,
   // results
   output logic irq,
   output logic ref1_disqualify
);
   import clock_event_pkg::*;

   // ********************************************
   // reset release
   // ********************************************
   logic [1:0] rst_sync_q;  // two-stage release
   logic rst_n;             // synchronised reset

   // stage 0 feeds only stage 1
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ********************************************
   // flag banks
   // ********************************************
   flag_bank_if ref_fb ();   // reference monitor flags
   flag_bank_if loop_fb ();  // loop zero and one flags
   flag_bank_if sys_fb ();   // system, rf, analog flags

   flag_bank #(.IMPL(`IMPL_REF)) u_ref_bank (
      .clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .fb(ref_fb)
   );
   flag_bank #(.IMPL(`IMPL_LOOP)) u_loop_bank (
      .clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .fb(loop_fb)
   );
   flag_bank #(.IMPL(`IMPL_SYS)) u_sys_bank (
      .clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .fb(sys_fb)
   );

   // ********************************************
   // input history for edge detection
   // ********************************************
   loop_state_t state_prev_q [3];  // 0 loop0, 1 loop1, 2 system
   logic [2:0] hold_prev_q;        // last holdover levels
   logic [2:0] lock_prev_q;        // last lock levels
   logic rf_lock_prev_q;           // last rf lock level
   logic [2:0] analog_prev_q;      // last analog lock levels
   logic primed_q;                 // history valid after first cycle
   loop_state_t state_now [3];     // current states as array
   logic [2:0] hold_now;           // current holdover levels
   logic [2:0] lock_now;           // current lock levels
   logic [2:0] state_chg;          // state change events
   logic [2:0] hold_chg;           // holdover entry or exit events
   logic [2:0] lock_loss;          // lock loss events
   logic rf_loss;                  // rf lock loss event
   logic [2:0] analog_loss;        // analog lock loss events

   assign state_now[0] = loop0_state;
   assign state_now[1] = loop1_state;
   assign state_now[2] = sys_state;
   assign hold_now = {sys_holdover, loop1_holdover, loop0_holdover};
   assign lock_now = {sys_locked, loop1_locked, loop0_locked};

   // history registers, captured every enabled cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_prev_q <= '{default: 3'h0};
         hold_prev_q <= 3'h0;
         lock_prev_q <= 3'h0;
         rf_lock_prev_q <= 1'b0;
         analog_prev_q <= 3'h0;
         primed_q <= 1'b0;
      end else if (ce) begin
         state_prev_q <= state_now;
         hold_prev_q <= hold_now;
         lock_prev_q <= lock_now;
         rf_lock_prev_q <= rf_locked;
         analog_prev_q <= analog_locked;
         primed_q <= 1'b1;
      end
   end

   // per-loop event detectors; first cycle only primes history
   for (genvar i = 0; i < 3; i++) begin : g_loop_evt
      assign state_chg[i] = primed_q && (state_now[i] != state_prev_q[i]);
      assign hold_chg[i] = primed_q && (hold_now[i] != hold_prev_q[i]);
      assign lock_loss[i] = primed_q && lock_prev_q[i] && !lock_now[i];
   end
   assign rf_loss = primed_q && rf_lock_prev_q && !rf_locked;
   assign analog_loss = {3{primed_q}} & analog_prev_q & ~analog_locked;

   // ********************************************
   // event to flag mapping
   // ********************************************
   // reference monitor failures, level sets the flag
   always_comb begin
      ref_fb.set = `FLAG_RST;
      ref_fb.set[`BIT_REF0_MT] = ref0_mt_fail;
      ref_fb.set[`BIT_REF0_LT] = ref0_lt_fail;
      ref_fb.set[`BIT_REF1_ST] = ref1_st_fail;
   end

   // loop zero low nibble, loop one high nibble, reserved bits 3 and 7 never set
   always_comb begin
      loop_fb.set = `FLAG_RST;
      loop_fb.set[`BIT_STATE] = state_chg[0];
      loop_fb.set[`BIT_HOLDOVER] = hold_chg[0];
      loop_fb.set[`BIT_UNLOCK] = lock_loss[0];
      loop_fb.set[`LOOP1_BASE + `BIT_STATE] = state_chg[1];
      loop_fb.set[`LOOP1_BASE + `BIT_HOLDOVER] = hold_chg[1];
      loop_fb.set[`LOOP1_BASE + `BIT_UNLOCK] = lock_loss[1];
   end

   // system loop high nibble, rf and analog low nibble
   always_comb begin
      sys_fb.set = `FLAG_RST;
      sys_fb.set[`LOOP1_BASE + `BIT_STATE] = state_chg[2];
      sys_fb.set[`LOOP1_BASE + `BIT_HOLDOVER] = hold_chg[2];
      sys_fb.set[`LOOP1_BASE + `BIT_UNLOCK] = lock_loss[2];
      sys_fb.set[`BIT_RF_UNLOCK] = rf_loss;
      sys_fb.set[`BIT_ANALOG_BASE +: 3] = analog_loss;
   end

   // ********************************************
   // register writes
   // ********************************************
   // write-one-to-clear strobes per bank
   assign ref_fb.clr = (wr_en && addr == `OFS_REF_FLAGS) ? wr_data : `FLAG_RST;
   assign loop_fb.clr = (wr_en && addr == `OFS_LOOP_FLAGS) ? wr_data : `FLAG_RST;
   assign sys_fb.clr = (wr_en && addr == `OFS_SYS_FLAGS) ? wr_data : `FLAG_RST;

   logic [7:0] ref_mask_q;   // reference monitor masks
   logic [7:0] loop_mask_q;  // loop zero and one masks
   logic [7:0] sys_mask_q;   // system, rf, analog masks

   // mask registers, unimplemented bits stay zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_mask_q <= `MASK_RST;
         loop_mask_q <= `MASK_RST;
         sys_mask_q <= `MASK_RST;
      end else if (ce && wr_en) begin
         case (addr)
            `OFS_REF_MASK: begin
               ref_mask_q <= wr_data & `IMPL_REF;
            end
            `OFS_LOOP_MASK: begin
               loop_mask_q <= wr_data & `IMPL_LOOP;
            end
            `OFS_SYS_MASK: begin
               sys_mask_q <= wr_data & `IMPL_SYS;
            end
            default: begin
               // other addresses leave masks alone
            end
         endcase
      end
   end

   // ********************************************
   // register reads
   // ********************************************
   logic [7:0] rd_data_q;  // read data, valid one cycle after strobe

   // read data only in the cycle after an enabled strobe, zero after other enabled cycles, held while ce is low
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_q <= `DATA_RST;
      end else if (ce) begin
         if (rd_en) begin
            case (addr)
               `OFS_REF_FLAGS: rd_data_q <= ref_fb.flags;
               `OFS_LOOP_FLAGS: rd_data_q <= loop_fb.flags;
               `OFS_SYS_FLAGS: rd_data_q <= sys_fb.flags;
               `OFS_REF_MASK: rd_data_q <= ref_mask_q;
               `OFS_LOOP_MASK: rd_data_q <= loop_mask_q;
               `OFS_SYS_MASK: rd_data_q <= sys_mask_q;
               default: rd_data_q <= `DATA_RST;  // unmapped reads zero
            endcase
         end else begin
            rd_data_q <= `DATA_RST;
         end
      end
   end
   assign rd_data = rd_data_q;

   // ********************************************
   // interrupt and disqualification
   // ********************************************
   logic pending;          // any unmasked flag set
   logic irq_q;            // registered interrupt level
   logic disqual_q;        // registered ref1 disqualification

   // masked flags combine into one request
   assign pending = |(ref_fb.flags & ~ref_mask_q)
                  | |(loop_fb.flags & ~loop_mask_q)
                  | |(sys_fb.flags & ~sys_mask_q);

   // outputs come from flip-flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
         disqual_q <= 1'b0;
      end else if (ce) begin
         irq_q <= pending;
         disqual_q <= ref1_st_fail && !ref_mask_q[`BIT_REF1_ST];
      end
   end
   assign irq = irq_q;
   assign ref1_disqualify = disqual_q;

   // ********************************************
   // checks
   // ********************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   chk_mt_flag_set: assert property (ce && ref0_mt_fail |=> ref_fb.flags[`BIT_REF0_MT])
      else $error("medium-term flag not set");
   chk_lt_flag_set: assert property (ce && ref0_lt_fail |=> ref_fb.flags[`BIT_REF0_LT])
      else $error("long-term flag not set");
   chk_w1c_clear: assert property (ce && wr_en && addr == `OFS_REF_FLAGS && wr_data[`BIT_REF0_MT]
      && !ref0_mt_fail |=> !ref_fb.flags[`BIT_REF0_MT])
      else $error("write one did not clear flag");
   chk_w1c_hold: assert property (ce && ref_fb.flags[`BIT_REF0_LT] && !(wr_en && addr == `OFS_REF_FLAGS
      && wr_data[`BIT_REF0_LT]) |=> ref_fb.flags[`BIT_REF0_LT])
      else $error("flag lost without a clear");
   chk_loop1_state: assert property (ce && primed_q && loop1_state != $past(loop1_state)
      && $past(ce) |=> loop_fb.flags[`LOOP1_BASE + `BIT_STATE])
      else $error("loop one state change missed");
   chk_loop1_holdover: assert property (ce && $past(ce) && primed_q && $changed(loop1_holdover)
      |=> loop_fb.flags[`LOOP1_BASE + `BIT_HOLDOVER])
      else $error("loop one holdover change missed");
   chk_loop0_unlock: assert property (ce && $past(ce) && primed_q && $fell(loop0_locked)
      |=> loop_fb.flags[`BIT_UNLOCK])
      else $error("loop zero lock loss missed");
   chk_sys_unlock: assert property (ce && $past(ce) && primed_q && $fell(sys_locked)
      |=> sys_fb.flags[`LOOP1_BASE + `BIT_UNLOCK])
      else $error("system loop lock loss missed");
   chk_loop1_unlock: assert property (ce && $past(ce) && primed_q && $fell(loop1_locked)
      |=> loop_fb.flags[`LOOP1_BASE + `BIT_UNLOCK])
      else $error("loop one lock loss missed");
   chk_loop0_state: assert property (ce && $past(ce) && primed_q && $changed(loop0_state)
      |=> loop_fb.flags[`BIT_STATE])
      else $error("loop zero state change missed");
   chk_sys_state: assert property (ce && $past(ce) && primed_q && $changed(sys_state)
      |=> sys_fb.flags[`LOOP1_BASE + `BIT_STATE])
      else $error("system loop state change missed");
   chk_sys_holdover: assert property (ce && $past(ce) && primed_q && $changed(sys_holdover)
      |=> sys_fb.flags[`LOOP1_BASE + `BIT_HOLDOVER])
      else $error("system loop holdover change missed");
   chk_rf_unlock: assert property (ce && $past(ce) && primed_q && $fell(rf_locked)
      |=> sys_fb.flags[`BIT_RF_UNLOCK])
      else $error("rf loop lock loss missed");
   chk_analog_unlock: assert property (ce && $past(ce) && primed_q && $fell(analog_locked[2])
      |=> sys_fb.flags[`BIT_ANALOG_BASE + 2])
      else $error("analog loop two lock loss missed");
   chk_rsvd_zero: assert property (!loop_fb.flags[3])
      else $error("reserved flag bit set");
   chk_irq_level: assert property (ce |=> irq == $past(pending))
      else $error("interrupt does not follow pending flags");
   chk_ref1_mask: assert property (ce && ref_mask_q[`BIT_REF1_ST] && sys_fb.flags == 8'h00
      && loop_fb.flags == 8'h00 && (ref_fb.flags & ~ref_mask_q) == 8'h00 |=> !irq)
      else $error("masked short-term failure raised interrupt");
   chk_disqual: assert property (ce && ref1_st_fail && !ref_mask_q[`BIT_REF1_ST] |=> ref1_disqualify
      ##0 $past(ref1_st_fail))
      else $error("unmasked short-term failure did not disqualify");
   chk_state_mask: assert property (ce && loop_mask_q[`LOOP1_BASE + `BIT_STATE]
      && loop_fb.flags[`LOOP1_BASE + `BIT_STATE] && (loop_fb.flags & ~loop_mask_q) == 8'h00
      && (ref_fb.flags & ~ref_mask_q) == 8'h00 && (sys_fb.flags & ~sys_mask_q) == 8'h00 |=> !irq)
      else $error("masked state change raised interrupt");
   chk_read_slot: assert property (ce && !rd_en |=> rd_data == 8'h00)
      else $error("read data outside its slot");

   cov_irq_rise: cover property (ce && !irq ##1 irq);
   cov_clear_race: cover property (ce && wr_en && addr == `OFS_REF_FLAGS && wr_data[`BIT_REF0_MT] && ref0_mt_fail);
   cov_analog_loss: cover property (ce && |analog_loss);
   cov_masked_flag: cover property (ref_fb.flags[`BIT_REF1_ST] && ref_mask_q[`BIT_REF1_ST]);
endmodule
`default_nettype wire

// ==== design/clock_event_pkg.sv ====
// types shared by the event latch block
package clock_event_pkg;
   typedef logic [15:0] reg_addr_t;   // register byte address
   typedef logic [7:0] reg_byte_t;    // register data byte
   typedef logic [2:0] loop_state_t;  // phase loop state code
endpackage

// ==== design/flag_bank.sv ====
// one byte of sticky write-one-to-clear event flags
`timescale 1ns/1ps
`default_nettype none
`include "clock_event_consts.svh"
module flag_bank #(
   parameter logic [7:0] IMPL = 8'hff  // bits that exist, others read zero
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // set and clear
   flag_bank_if.bank fb
);
   import clock_event_pkg::*;

   logic [7:0] flags_q;  // latched flags

   // ********************************************
   // sticky flags, set wins over clear
   // ********************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= `FLAG_RST;
      end else if (ce) begin
         flags_q <= ((flags_q & ~fb.clr) | fb.set) & IMPL;
      end
   end

   assign fb.flags = flags_q;
endmodule
`default_nettype wire

// ==== design/flag_bank_if.sv ====
// set, clear and flag bundle between the latch core and a flag bank
`timescale 1ns/1ps
`default_nettype none
interface flag_bank_if;
   logic [7:0] set;    // hardware event pulses
   logic [7:0] clr;    // write-one-to-clear pulses
   logic [7:0] flags;  // latched flags
   modport core (output set, output clr, input flags);
   modport bank (input set, input clr, output flags);
endinterface
`default_nettype wire

// ==== tb/clock_event_latch_tb.sv ====
// self-checking testbench of the clock event latch block
`timescale 1ns/1ps
`default_nettype none
`include "clock_event_consts.svh"
module clock_event_latch_tb;
   import clock_event_pkg::*;

   // ********************************************
   // stimulus and observed signals
   // ********************************************
   logic core_clk;                  // 200 MHz core clock
   logic arst_n;                    // async reset, active low
   logic ce;                        // clock enable
   reg_addr_t addr;                 // register address
   reg_byte_t wr_data;              // register write data
   logic wr_en;                     // write strobe
   logic rd_en;                     // read strobe
   logic [7:0] rd_data;             // register read data
   logic ref0_mt_fail;              // ref0 medium-term failure
   logic ref0_lt_fail;              // ref0 long-term failure
   logic ref1_st_fail;              // ref1 short-term failure
   loop_state_t loop0_state;        // loop zero state code
   logic loop0_holdover;            // loop zero holdover level
   logic loop0_locked;              // loop zero lock level
   loop_state_t loop1_state;        // loop one state code
   logic loop1_holdover;            // loop one holdover level
   logic loop1_locked;              // loop one lock level
   loop_state_t sys_state;          // system loop state code
   logic sys_holdover;              // system loop holdover level
   logic sys_locked;                // system loop lock level
   logic rf_locked;                 // rf loop lock level
   logic [2:0] analog_locked;       // analog loop lock levels
   logic irq;                       // interrupt output
   logic ref1_disqualify;           // ref1 disqualified
   int n_mismatch;                  // mismatches seen
   int num_checks;                  // comparisons made
   reg_byte_t v;                    // last read value

   // ********************************************
   // device under test
   // ********************************************
   clock_event_latch dut (.core_clk(core_clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ref0_mt_fail(ref0_mt_fail),
      .ref0_lt_fail(ref0_lt_fail), .ref1_st_fail(ref1_st_fail), .loop0_state(loop0_state),
      .loop0_holdover(loop0_holdover), .loop0_locked(loop0_locked), .loop1_state(loop1_state),
      .loop1_holdover(loop1_holdover), .loop1_locked(loop1_locked), .sys_state(sys_state),
      .sys_holdover(sys_holdover), .sys_locked(sys_locked), .rf_locked(rf_locked),
      .analog_locked(analog_locked), .irq(irq), .ref1_disqualify(ref1_disqualify));

   // clock generator, 5 ns period
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // ********************************************
   // shared tasks
   // ********************************************
   // compare a seen byte with the expected one
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // wait a number of core clock edges
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // one-cycle register write
   task automatic wr(input reg_addr_t a, input reg_byte_t d);
      @(posedge core_clk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask

   // one-cycle register read, data taken in the following cycle
   task automatic rd(input reg_addr_t a, output reg_byte_t d);
      @(posedge core_clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask

   // read a latched event, clear it by writing one, read it cleared
   task automatic evt_check(input reg_addr_t a, input reg_byte_t exp);
      idle(2);
      rd(a, v);
      check("event flag", v, exp);
      wr(a, exp);
      rd(a, v);
      check("flag cleared", v, 8'h00);
   endtask

   // verdict and end of run
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ********************************************
   // scenarios
   // ********************************************
   // reset values, mask access, unmapped place, read data standing one cycle
   task automatic t_registers();
      for (int i = 0; i < 6; i++) begin
         rd(`OFS_REF_FLAGS + 16'(i), v);
         check("reset value", v, 8'h00);
      end
      check("irq at reset", {7'h00, irq}, 8'h00);
      wr(`OFS_REF_MASK, 8'hff);
      wr(`OFS_LOOP_MASK, 8'hf7);
      wr(`OFS_SYS_MASK, 8'hff);
      rd(`OFS_REF_MASK, v);
      check("ref mask", v, 8'h43);
      idle(1);
      #1 check("rd data after", rd_data, 8'h00);
      rd(`OFS_LOOP_MASK, v);
      check("loop mask", v, 8'h77);
      rd(`OFS_SYS_MASK, v);
      check("sys mask", v, 8'h7f);
      wr(16'h00e8, 8'hff);
      rd(16'h00e8, v);
      check("unmapped", v, 8'h00);
      wr(`OFS_REF_MASK, 8'h00);
      wr(`OFS_LOOP_MASK, 8'h00);
      wr(`OFS_SYS_MASK, 8'h00);
   endtask

   // ref0 monitor failures and the write-one-to-clear rule
   task automatic t_ref_monitors();
      @(posedge core_clk) ref0_mt_fail <= 1'b1;
      @(posedge core_clk) ref0_mt_fail <= 1'b0;
      idle(2);
      rd(`OFS_REF_FLAGS, v);
      check("mt flag", v, 8'h02);
      check("irq mt", {7'h00, irq}, 8'h01);
      wr(`OFS_REF_FLAGS, 8'h00);
      rd(`OFS_REF_FLAGS, v);
      check("write zero keeps", v, 8'h02);
      wr(`OFS_REF_FLAGS, 8'h01);
      rd(`OFS_REF_FLAGS, v);
      check("other bit keeps", v, 8'h02);
      wr(`OFS_REF_FLAGS, 8'h02);
      rd(`OFS_REF_FLAGS, v);
      check("write one clears", v, 8'h00);
      idle(2);
      #1 check("irq released", {7'h00, irq}, 8'h00);
      @(posedge core_clk) ref0_lt_fail <= 1'b1;
      @(posedge core_clk) ref0_lt_fail <= 1'b0;
      evt_check(`OFS_REF_FLAGS, 8'h01);
   endtask

   // every loop event, both holdover directions on loops zero and one, lock regain silent
   task automatic t_loop_events();
      @(posedge core_clk) loop0_locked <= 1'b0;
      evt_check(`OFS_LOOP_FLAGS, 8'h01);
      @(posedge core_clk) loop0_locked <= 1'b1;
      idle(2);
      rd(`OFS_LOOP_FLAGS, v);
      check("relock silent", v, 8'h00);
      @(posedge core_clk) loop0_holdover <= 1'b1;
      evt_check(`OFS_LOOP_FLAGS, 8'h02);
      @(posedge core_clk) loop0_holdover <= 1'b0;
      evt_check(`OFS_LOOP_FLAGS, 8'h02);
      @(posedge core_clk) loop0_state <= 3'h5;
      evt_check(`OFS_LOOP_FLAGS, 8'h04);
      @(posedge core_clk) loop1_locked <= 1'b0;
      evt_check(`OFS_LOOP_FLAGS, 8'h10);
      @(posedge core_clk) loop1_holdover <= 1'b1;
      evt_check(`OFS_LOOP_FLAGS, 8'h20);
      @(posedge core_clk) loop1_holdover <= 1'b0;
      evt_check(`OFS_LOOP_FLAGS, 8'h20);
      @(posedge core_clk) loop1_state <= 3'h3;
      evt_check(`OFS_LOOP_FLAGS, 8'h40);
      @(posedge core_clk) sys_locked <= 1'b0;
      evt_check(`OFS_SYS_FLAGS, 8'h10);
      @(posedge core_clk) sys_holdover <= 1'b1;
      evt_check(`OFS_SYS_FLAGS, 8'h20);
      @(posedge core_clk) sys_state <= 3'h6;
      evt_check(`OFS_SYS_FLAGS, 8'h40);
      @(posedge core_clk) rf_locked <= 1'b0;
      evt_check(`OFS_SYS_FLAGS, 8'h08);
      @(posedge core_clk) analog_locked <= 3'b101;
      evt_check(`OFS_SYS_FLAGS, 8'h02);
      @(posedge core_clk) analog_locked <= 3'b000;
      evt_check(`OFS_SYS_FLAGS, 8'h05);
   endtask

   // masks hold off the interrupt and the disqualification
   task automatic t_masks();
      wr(`OFS_LOOP_MASK, 8'h40);
      @(posedge core_clk) loop1_state <= 3'h1;
      idle(2);
      rd(`OFS_LOOP_FLAGS, v);
      check("masked flag", v, 8'h40);
      check("masked irq", {7'h00, irq}, 8'h00);
      wr(`OFS_LOOP_MASK, 8'h00);
      idle(2);
      #1 check("unmasked irq", {7'h00, irq}, 8'h01);
      wr(`OFS_LOOP_FLAGS, 8'h40);
      idle(2);
      #1 check("irq cleared", {7'h00, irq}, 8'h00);
      wr(`OFS_REF_MASK, 8'h40);
      @(posedge core_clk) ref1_st_fail <= 1'b1;
      idle(3);
      #1 check("st masked irq", {7'h00, irq}, 8'h00);
      check("st masked disq", {7'h00, ref1_disqualify}, 8'h00);
      wr(`OFS_REF_MASK, 8'h00);
      idle(2);
      #1 check("st irq", {7'h00, irq}, 8'h01);
      check("st disq", {7'h00, ref1_disqualify}, 8'h01);
      @(posedge core_clk) ref1_st_fail <= 1'b0;
      evt_check(`OFS_REF_FLAGS, 8'h40);
      check("st disq gone", {7'h00, ref1_disqualify}, 8'h00);
      check("st irq gone", {7'h00, irq}, 8'h00);
   endtask

   // a failure seen only while the enable is low leaves no flag
   task automatic t_enable_low();
      @(posedge core_clk) ce <= 1'b0;
      @(posedge core_clk) ref0_lt_fail <= 1'b1;
      idle(2);
      ref0_lt_fail <= 1'b0;
      @(posedge core_clk) ce <= 1'b1;
      idle(2);
      rd(`OFS_REF_FLAGS, v);
      check("frozen", v, 8'h00);
   endtask

   // a second reset in mid-run clears flags and masks
   task automatic t_second_reset();
      wr(`OFS_SYS_MASK, 8'h7f);
      @(posedge core_clk) ref0_mt_fail <= 1'b1;
      @(posedge core_clk) ref0_mt_fail <= 1'b0;
      idle(2);
      arst_n <= 1'b0;
      idle(3);
      arst_n <= 1'b1;
      idle(4);
      rd(`OFS_REF_FLAGS, v);
      check("flag after reset", v, 8'h00);
      rd(`OFS_SYS_MASK, v);
      check("mask after reset", v, 8'h00);
      check("irq after reset", {7'h00, irq}, 8'h00);
   endtask

   // ********************************************
   // main sequence and watchdog
   // ********************************************
   initial begin
      n_mismatch = 0;
      num_checks = 0;
      {arst_n, wr_en, rd_en, addr, wr_data} = '0;
      ce = 1'b1;
      {ref0_mt_fail, ref0_lt_fail, ref1_st_fail} = 3'b000;
      {loop0_state, loop1_state, sys_state} = '0;
      {loop0_holdover, loop1_holdover, sys_holdover} = 3'b000;
      {loop0_locked, loop1_locked, sys_locked, rf_locked} = 4'hf;
      analog_locked = 3'b111;
      idle(8);
      arst_n <= 1'b1;
      idle(4);
      t_registers();
      t_ref_monitors();
      t_loop_events();
      t_masks();
      t_enable_low();
      t_second_reset();
      complete_run();
   end

   // hang guard, counts as a mismatch
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      complete_run();
   end
endmodule
`default_nettype wire
